// ---- rtl/dis_pkg.sv ----
// constants for the dac interrupt status and overflow block
package dis_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_EVENT_MID = 12'h024;
    localparam logic [11:0] ADDR_EVENT_HIGH = 12'h025;
    localparam logic [11:0] ADDR_OVF_FLAGS = 12'h026;
    localparam logic [11:0] ADDR_DC_OVF = 12'h027;
    // event_status_mid bit positions
    localparam int MID_INPHASE_BIT = 0;
    localparam int MID_QUAD_BIT = 1;
    localparam int MID_OVERFLOW_BIT = 3;
    localparam int MID_DATA_READY_BIT = 4;
    // event_status_high bit positions
    localparam int HIGH_TRIP_BIT = 0;
    localparam int HIGH_WINDOW_BIT = 1;
    localparam int HIGH_ROTATED_BIT = 2;
    localparam int HIGH_LOCKED_BIT = 3;
    localparam int HIGH_OSC_ALIGN_BIT = 4;
    localparam int HIGH_POWER_BIT = 7;
    // implemented bits; all others read zero
    localparam logic [7:0] MID_USED_MASK = 8'h1B;
    localparam logic [7:0] HIGH_USED_MASK = 8'h9F;
    localparam logic [7:0] DC_OVF_MASK = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// ---- rtl/dis_irq_status.sv ----
// interrupt status bytes, overflow status bytes and active-low interrupt pin
// How it works
// - enable low: bit shows live source, no latch
// - enable high: latch rising edge, pull pin low
// - writing one clears latched bit; zero keeps
// - data ready at mid byte bit 4
// - overflow at bit 3; bit 2 reserved zero
// - quad check fail bit 1, inphase bit 0
// - power threshold error at high byte bit 7
// - oscillator align bit 4; bits 6:5 reserved
// - multiframe align locked at high bit 3
// - multiframe align rotated at high bit 2
// - phase out of window bit 1, own enable
// - multiframe align tripped at high bit 0
// - read-only datapath overflow byte, eight flags
// - dc shift overflow bit 0, rest zero
`timescale 1ns/100ps
`default_nettype none
module dis_irq_status (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // register access
    input wire logic [11:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // event sources
    input wire logic i_data_ready_flag,
    input wire logic i_datapath_overflow,
    input wire logic i_quad_seq_check_fail,
    input wire logic i_inphase_seq_check_fail,
    input wire logic i_power_threshold_error,
    input wire logic i_osc_align_tripped,
    input wire logic i_multiframe_align_locked,
    input wire logic i_multiframe_align_rotated,
    input wire logic i_multiframe_phase_out_of_window,
    input wire logic i_multiframe_align_tripped,
    // per-source interrupt enables
    input wire logic i_data_ready_int_enable,
    input wire logic i_overflow_int_enable,
    input wire logic i_quad_seq_int_enable,
    input wire logic i_inphase_seq_int_enable,
    input wire logic i_power_threshold_int_enable,
    input wire logic i_osc_align_int_enable,
    input wire logic i_align_locked_int_enable,
    input wire logic i_align_rotated_int_enable,
    input wire logic i_window_limit_int_enable,
    input wire logic i_align_trip_int_enable,
    // datapath overflow sources
    input wire logic i_prog_filter_ovf,
    input wire logic i_interp_stage1_ovf,
    input wire logic i_interp_stage2_ovf,
    input wire logic i_interp_stage3_ovf,
    input wire logic i_eighth_rate_mod_ovf,
    input wire logic i_fine_mixer_ovf,
    input wire logic i_phase_adjust_ovf,
    input wire logic i_gain_adjust_ovf,
    input wire logic i_dc_shift_ovf,
    // interrupt pin
    output logic o_irq_n
);
    logic [7:0] src_mid;
    logic [7:0] src_high;
    logic [7:0] en_mid;
    logic [7:0] en_high;
    logic [7:0] prev_mid_ff;
    logic [7:0] prev_high_ff;
    logic [7:0] lat_mid_ff;
    logic [7:0] lat_high_ff;
    logic [7:0] nxt_lat_mid;
    logic [7:0] nxt_lat_high;
    logic [7:0] view_mid;
    logic [7:0] view_high;
    logic [7:0] ovf_flags;
    logic [7:0] dc_ovf;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    logic irq_n_ff;

    // next latch value: clear by write-one, hardware set wins over the clear
    function automatic logic [7:0] latch_next(
        input logic [7:0] lat,
        input logic [7:0] src,
        input logic [7:0] prev,
        input logic [7:0] en,
        input logic [7:0] clr
    );
        logic [7:0] rise;
        rise = src & ~prev;
        latch_next = ((lat & ~clr) | (rise & en)) & en;
    endfunction

    // bit 2 and bits 7:5 read zero
    always_comb begin
        src_mid = dis_pkg::STATUS_RESET;
        src_mid[dis_pkg::MID_DATA_READY_BIT] = i_data_ready_flag;
        src_mid[dis_pkg::MID_OVERFLOW_BIT] = i_datapath_overflow;
        src_mid[dis_pkg::MID_QUAD_BIT] = i_quad_seq_check_fail;
        src_mid[dis_pkg::MID_INPHASE_BIT] = i_inphase_seq_check_fail;
        en_mid = dis_pkg::STATUS_RESET;
        en_mid[dis_pkg::MID_DATA_READY_BIT] = i_data_ready_int_enable;
        en_mid[dis_pkg::MID_OVERFLOW_BIT] = i_overflow_int_enable;
        en_mid[dis_pkg::MID_QUAD_BIT] = i_quad_seq_int_enable;
        en_mid[dis_pkg::MID_INPHASE_BIT] = i_inphase_seq_int_enable;
    end

    always_comb begin
        src_high = dis_pkg::STATUS_RESET;
        src_high[dis_pkg::HIGH_POWER_BIT] = i_power_threshold_error;
        src_high[dis_pkg::HIGH_OSC_ALIGN_BIT] = i_osc_align_tripped;
        src_high[dis_pkg::HIGH_LOCKED_BIT] = i_multiframe_align_locked;
        src_high[dis_pkg::HIGH_ROTATED_BIT] = i_multiframe_align_rotated;
        src_high[dis_pkg::HIGH_WINDOW_BIT] = i_multiframe_phase_out_of_window;
        src_high[dis_pkg::HIGH_TRIP_BIT] = i_multiframe_align_tripped;
        en_high = dis_pkg::STATUS_RESET;
        en_high[dis_pkg::HIGH_POWER_BIT] = i_power_threshold_int_enable;
        en_high[dis_pkg::HIGH_OSC_ALIGN_BIT] = i_osc_align_int_enable;
        en_high[dis_pkg::HIGH_LOCKED_BIT] = i_align_locked_int_enable;
        en_high[dis_pkg::HIGH_ROTATED_BIT] = i_align_rotated_int_enable;
        en_high[dis_pkg::HIGH_WINDOW_BIT] = i_window_limit_int_enable;
        en_high[dis_pkg::HIGH_TRIP_BIT] = i_align_trip_int_enable;
    end

    // only bit 0 of the second byte is used
    always_comb begin
        ovf_flags = {i_prog_filter_ovf, i_interp_stage1_ovf, i_interp_stage2_ovf,
                     i_interp_stage3_ovf, i_eighth_rate_mod_ovf, i_fine_mixer_ovf,
                     i_phase_adjust_ovf, i_gain_adjust_ovf};
        dc_ovf = {7'h00, i_dc_shift_ovf} & dis_pkg::DC_OVF_MASK;
    end

    // write-one clear, zero leaves bits alone
    always_comb begin
        nxt_lat_mid = latch_next(lat_mid_ff, src_mid, prev_mid_ff, en_mid,
            (i_reg_wr && i_reg_addr == dis_pkg::ADDR_EVENT_MID) ? i_reg_wdata : 8'h00);
        nxt_lat_high = latch_next(lat_high_ff, src_high, prev_high_ff, en_high,
            (i_reg_wr && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH) ? i_reg_wdata : 8'h00);
    end

    // disabled bits show the live source
    always_comb begin
        view_mid = ((lat_mid_ff & en_mid) | (src_mid & ~en_mid)) & dis_pkg::MID_USED_MASK;
        view_high = ((lat_high_ff & en_high) | (src_high & ~en_high))
            & dis_pkg::HIGH_USED_MASK;
    end

    // edge history; a source already high when enabled does not latch until it rises again
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            prev_mid_ff <= dis_pkg::STATUS_RESET;
            prev_high_ff <= dis_pkg::STATUS_RESET;
        end else begin
            prev_mid_ff <= src_mid;
            prev_high_ff <= src_high;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            lat_mid_ff <= dis_pkg::STATUS_RESET;
            lat_high_ff <= dis_pkg::STATUS_RESET;
        end else begin
            lat_mid_ff <= nxt_lat_mid;
            lat_high_ff <= nxt_lat_high;
        end
    end

    // pin low while any latched bit remains
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= ~(|nxt_lat_mid | |nxt_lat_high);
        end
    end

    always_comb begin
        if (i_reg_addr == dis_pkg::ADDR_EVENT_MID) begin
            nxt_rdata = view_mid;
        end else if (i_reg_addr == dis_pkg::ADDR_EVENT_HIGH) begin
            nxt_rdata = view_high;
        end else if (i_reg_addr == dis_pkg::ADDR_OVF_FLAGS) begin
            nxt_rdata = ovf_flags;
        end else if (i_reg_addr == dis_pkg::ADDR_DC_OVF) begin
            nxt_rdata = dc_ovf;
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    // read data holds until the next read
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rdata_ff <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_irq_n = irq_n_ff;

    default clocking dflt_cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    // a latch taken under last cycle's enable still stands in the cycle that enable drops
    chk_live_disabled: assert property (
        (lat_mid_ff & ~$past(en_mid)) == 8'h00 && (lat_high_ff & ~$past(en_high)) == 8'h00)
        else $error("latched bit present with enable low");

    chk_rise_latches: assert property (
        i_data_ready_int_enable && i_data_ready_flag && !prev_mid_ff[4] ##1
        i_data_ready_int_enable |-> lat_mid_ff[4] && !o_irq_n)
        else $error("enabled rising edge did not latch or pull pin");

    chk_zero_write_keeps: assert property (
        i_reg_wr && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH && i_reg_wdata == 8'h00
        |=> ((($past(lat_high_ff) & $past(en_high) & en_high) & ~lat_high_ff) == 8'h00))
        else $error("zero write lost a latched bit");

    chk_one_write_clears: assert property (
        i_reg_wr && i_reg_addr == dis_pkg::ADDR_EVENT_MID && i_reg_wdata[3]
        && !(i_datapath_overflow && !prev_mid_ff[3]) |=> !lat_mid_ff[3])
        else $error("write one did not clear bit");

    chk_mid_reserved_zero: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_MID |=> o_reg_rdata[2] == 1'b0
        && o_reg_rdata[7:5] == 3'b000)
        else $error("reserved mid bits nonzero");

    chk_high_reserved_zero: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH |=> o_reg_rdata[6:5] == 2'b00)
        else $error("reserved high bits nonzero");

    chk_power_live_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH && !i_power_threshold_int_enable
        |=> o_reg_rdata[7] == $past(i_power_threshold_error))
        else $error("power bit not live");

    chk_ovf_byte_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_OVF_FLAGS
        |=> o_reg_rdata == {$past(i_prog_filter_ovf), $past(i_interp_stage1_ovf),
            $past(i_interp_stage2_ovf), $past(i_interp_stage3_ovf),
            $past(i_eighth_rate_mod_ovf), $past(i_fine_mixer_ovf),
            $past(i_phase_adjust_ovf), $past(i_gain_adjust_ovf)})
        else $error("overflow byte mismatch");

    chk_dc_byte_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_DC_OVF
        |=> o_reg_rdata == {7'h00, $past(i_dc_shift_ovf)})
        else $error("dc overflow byte mismatch");

    chk_pin_tracks_latch: assert property (
        o_irq_n == !(|lat_mid_ff || |lat_high_ff))
        else $error("interrupt pin disagrees with latched bits");

    chk_pin_releases: assert property (
        $fell(|lat_mid_ff || |lat_high_ff) |-> o_irq_n)
        else $error("interrupt pin held after last latch cleared");

    chk_disabled_no_pin: assert property (
        en_mid == 8'h00 && en_high == 8'h00 |=> o_irq_n)
        else $error("interrupt pin pulled with every enable low");

    chk_osc_align_latch: assert property (
        i_osc_align_int_enable && i_osc_align_tripped
        && !prev_high_ff[dis_pkg::HIGH_OSC_ALIGN_BIT]
        |=> lat_high_ff[dis_pkg::HIGH_OSC_ALIGN_BIT] && !o_irq_n)
        else $error("oscillator align rise did not latch");

    // the window bit has an enable of its own, separate from the other alignment events
    chk_window_own_enable: assert property (
        !i_window_limit_int_enable |=> !lat_high_ff[dis_pkg::HIGH_WINDOW_BIT])
        else $error("window bit latched with its enable low");

    chk_ready_live_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_MID && !i_data_ready_int_enable
        |=> o_reg_rdata[dis_pkg::MID_DATA_READY_BIT] == $past(i_data_ready_flag))
        else $error("data ready bit not live");

    chk_seq_live_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_MID
        && !i_quad_seq_int_enable && !i_inphase_seq_int_enable
        |=> o_reg_rdata[1:0] == {$past(i_quad_seq_check_fail), $past(i_inphase_seq_check_fail)})
        else $error("sequence check bits not live");

    chk_locked_latched_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH && i_align_locked_int_enable
        |=> o_reg_rdata[dis_pkg::HIGH_LOCKED_BIT]
        == $past(lat_high_ff[dis_pkg::HIGH_LOCKED_BIT]))
        else $error("locked bit does not show its latch");

    chk_rotated_latched_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH && i_align_rotated_int_enable
        |=> o_reg_rdata[dis_pkg::HIGH_ROTATED_BIT]
        == $past(lat_high_ff[dis_pkg::HIGH_ROTATED_BIT]))
        else $error("rotated bit does not show its latch");

    chk_trip_latched_read: assert property (
        i_reg_rd && i_reg_addr == dis_pkg::ADDR_EVENT_HIGH && i_align_trip_int_enable
        |=> o_reg_rdata[dis_pkg::HIGH_TRIP_BIT]
        == $past(lat_high_ff[dis_pkg::HIGH_TRIP_BIT]))
        else $error("tripped bit does not show its latch");
endmodule
`default_nettype wire

// ---- sim/dis_host_model.sv ----
// host model: strobe-bus register reads and write-one-to-clear servicing
`timescale 1ns/100ps
`default_nettype none
module dis_host_model (
    // clock
    input wire logic i_clock,
    // register access
    output logic [11:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_rd,
    input wire logic [7:0] i_reg_rdata
);
    initial begin
        o_reg_addr = 12'h000;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd = 1'b0;
    end
    // gap cycles model a slow host; released address and data lines show inverted values, not stale ones; the strobes drop low
    task automatic access(input logic [11:0] a, input logic w, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge i_clock);
        @(posedge i_clock);
        o_reg_addr <= a;
        o_reg_wr <= w;
        o_reg_rd <= ~w;
        o_reg_wdata <= d;
        @(posedge i_clock);
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask
    task automatic read_byte(input logic [11:0] a, input int gap, output logic [7:0] d);
        access(a, 1'b0, 8'h00, gap);
        @(negedge i_clock);
        d = i_reg_rdata;
    endtask
    // a one clears, a zero keeps
    task automatic write_byte(input logic [11:0] a, input logic [7:0] d, input int gap);
        access(a, 1'b1, d, gap);
    endtask
endmodule
`default_nettype wire

// ---- sim/dac_irq_status_overflow_test.sv ----
// self-checking bench for the interrupt status and overflow block
`timescale 1ns/100ps
`default_nettype none
module dac_irq_status_overflow_test;
    logic clk, srst, wr, rd, irq_n;
    logic [11:0] addr;
    logic [7:0] wd, rdata, exp_rd, got;
    // sources: 0 inphase 1 quad 2 overflow 3 ready 4 trip 5 window 6 rotated 7 locked 8 osc 9 power
    logic [9:0] s, e, prv, lat;
    logic [8:0] v;
    int bad_count, comparisons;

    dis_host_model host (.i_clock(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wd),
        .o_reg_rd(rd), .i_reg_rdata(rdata));
    dis_irq_status dut (.i_clock(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq_n(irq_n),
        .i_inphase_seq_check_fail(s[0]), .i_quad_seq_check_fail(s[1]),
        .i_datapath_overflow(s[2]), .i_data_ready_flag(s[3]), .i_multiframe_align_tripped(s[4]),
        .i_multiframe_phase_out_of_window(s[5]), .i_multiframe_align_rotated(s[6]),
        .i_multiframe_align_locked(s[7]), .i_osc_align_tripped(s[8]),
        .i_power_threshold_error(s[9]), .i_inphase_seq_int_enable(e[0]),
        .i_quad_seq_int_enable(e[1]), .i_overflow_int_enable(e[2]),
        .i_data_ready_int_enable(e[3]), .i_align_trip_int_enable(e[4]),
        .i_window_limit_int_enable(e[5]), .i_align_rotated_int_enable(e[6]),
        .i_align_locked_int_enable(e[7]), .i_osc_align_int_enable(e[8]),
        .i_power_threshold_int_enable(e[9]), .i_prog_filter_ovf(v[8]),
        .i_interp_stage1_ovf(v[7]), .i_interp_stage2_ovf(v[6]), .i_interp_stage3_ovf(v[5]),
        .i_eighth_rate_mod_ovf(v[4]), .i_fine_mixer_ovf(v[3]), .i_phase_adjust_ovf(v[2]),
        .i_gain_adjust_ovf(v[1]), .i_dc_shift_ovf(v[0]));

    // byte as the host should see it: latched where enabled, live elsewhere
    function automatic logic [7:0] view(input logic [11:0] a);
        logic [9:0] x;
        x = (e & lat) | (~e & s);
        case (a)
            dis_pkg::ADDR_EVENT_MID: view = {3'h0, x[3], x[2], 1'b0, x[1], x[0]};
            dis_pkg::ADDR_EVENT_HIGH: view = {x[9], 2'h0, x[8:4]};
            dis_pkg::ADDR_OVF_FLAGS: view = v[8:1];
            dis_pkg::ADDR_DC_OVF: view = {7'h00, v[0]};
            default: view = 8'h00;
        endcase
    endfunction
    function automatic logic [9:0] clr_of(input logic [11:0] a, input logic [7:0] d);
        if (a == dis_pkg::ADDR_EVENT_MID) clr_of = {6'h00, d[4], d[3], d[1], d[0]};
        else if (a == dis_pkg::ADDR_EVENT_HIGH) clr_of = {d[7], d[4:0], 4'h0};
        else clr_of = 10'h000;
    endfunction
    task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
        comparisons++;
        if (got_v !== exp_v) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input int gap);
        host.read_byte(a, gap, got);
        check(got, exp_rd);
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // reference state, sampled at the same edges the design samples; set wins over clear
    always @(posedge clk) begin
        if (srst) begin
            lat <= 10'h000;
            prv <= 10'h000;
            exp_rd <= 8'h00;
        end else begin
            check({7'h00, irq_n}, {7'h00, ~|lat});
            if (rd) exp_rd <= view(addr);
            prv <= s;
            lat <= ((lat & ~(wr ? clr_of(addr, wd) : 10'h000)) | (s & ~prv)) & e;
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        int i, w;
        logic [11:0] a;
        srst = 1'b1;
        s = 10'h000;
        e = 10'h000;
        v = 9'h000;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(37));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 6; i++) rd_chk(12'h024 + 12'(i), 0);
        // each source alone: latch on rise, zero write keeps, one write clears
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            e <= 10'h001 << i;
            s <= 10'h000;
            @(posedge clk);
            s <= 10'h001 << i;
            for (w = 0; w < 2; w++) begin
                host.write_byte(dis_pkg::ADDR_EVENT_MID, w ? 8'hFF : 8'h00, 0);
                host.write_byte(dis_pkg::ADDR_EVENT_HIGH, w ? 8'hFF : 8'h00, 0);
                rd_chk(dis_pkg::ADDR_EVENT_MID, 0);
                rd_chk(dis_pkg::ADDR_EVENT_HIGH, 0);
            end
        end
        // random traffic: sources toggle, enables drop and rise, writes hit every byte
        for (i = 0; i < 500; i++) begin
            @(posedge clk);
            s <= s ^ 10'($urandom & $urandom);
            if ($urandom_range(7) == 0) e <= 10'($urandom);
            v <= 9'($urandom & $urandom);
            a = 12'h024 + 12'($urandom_range(4));
            if ($urandom_range(3) == 0) host.write_byte(a, 8'($urandom), $urandom_range(2));
            else rd_chk(a, $urandom_range(2));
        end
        // reset in mid-run with every source latched: latches and pin return to idle
        @(posedge clk);
        e <= 10'h3FF;
        s <= 10'h000;
        @(posedge clk);
        s <= 10'h3FF;
        repeat (2) @(posedge clk);
        srst <= 1'b1;
        s <= 10'h000;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_chk(dis_pkg::ADDR_EVENT_MID, 0);
        rd_chk(dis_pkg::ADDR_EVENT_HIGH, 0);
        complete_run();
    end
endmodule
`default_nettype wire
